// file: logic/mrx_pkg.sv
// Package: constants, encodings and carrier types for the move/return executor
package mrx_pkg;

    // ============================================================
    // Widths
    localparam int MRX_IW = 14;             // Instruction word width
    localparam int MRX_DW = 8;              // Accumulator / file data width
    localparam int MRX_FW = 7;              // File address width
    localparam int MRX_PW = 13;             // Program counter width

    // ============================================================
    // Encodings
    localparam logic [6:0] MRX_STORE_TOP = 7'h01;       // Bits 13:7 of store op
    localparam logic [3:0] MRX_LOADLIT_TOP = 4'hC;      // Bits 13:10 of load literal
    localparam logic [3:0] MRX_RETLIT_TOP = 4'hD;       // Bits 13:10 of return literal
    localparam logic [13:0] MRX_IRQRET_WORD = 14'h0009; // Interrupt return
    localparam logic [13:0] MRX_SUBRET_WORD = 14'h0008; // Subroutine return
    localparam logic [13:0] MRX_NOP_MASK = 14'h3F9F;    // Cares of no-operation
    localparam logic [13:0] MRX_NOP_WORD = 14'h0000;    // Cared bits of no-operation

    // ============================================================
    // Reset values and cycle counts
    localparam logic [7:0] MRX_ACC_RST = 8'h00;     // Accumulator after reset
    localparam logic MRX_GIE_RST = 1'b0;            // Interrupts off after reset
    localparam int MRX_RET_CYCLES = 2;              // Cycles of every return op
    localparam int MRX_ONE_CYCLES = 1;              // Cycles of all other ops

    // ============================================================
    // State machine
    typedef enum logic [1:0] {
        MRX_EXEC = 2'b01,     // Ready for an instruction
        MRX_SECOND = 2'b10    // Second cycle of a return
    } mrx_state_t;

    // ============================================================
    // Carriers
    typedef struct packed {
        logic valid;                 // Word offered by fetch
        logic [13:0] word;           // Instruction word
    } mrx_instr_t;

    typedef struct packed {
        logic en;                    // One-cycle write strobe
        logic [6:0] addr;            // File register address
        logic [7:0] data;            // Data to write
    } mrx_file_wr_t;

    typedef struct packed {
        logic load;                  // One-cycle program counter load
        logic pop;                   // One-cycle return stack pop
        logic [12:0] value;          // Value to load
    } mrx_pc_ctl_t;

endpackage : mrx_pkg

// file: logic/mrx_exec.sv
// Decode and execute of store, literal, no-operation and return instructions
// What this block does
// [RULE_01] Store op copies accumulator to file, one cycle
// [RULE_02] Interrupt return reloads counter, sets irq enable
// [RULE_03] Subroutine return pops stack into counter, two cycles
// [RULE_04] Return literal puts its byte into accumulator
// [RULE_05] Return literal also reloads counter, two cycles
// [RULE_06] Load literal writes accumulator; no-operation changes nothing
module mrx_exec (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    // Instruction from fetch
    input wire mrx_pkg::mrx_instr_t instr,
    output logic instr_ready,
    // Return stack head from the datapath
    input wire logic [mrx_pkg::MRX_PW-1:0] stack_head,
    // Results towards the datapath
    output mrx_pkg::mrx_file_wr_t file_wr,
    output mrx_pkg::mrx_pc_ctl_t pc_ctl,
    output logic [mrx_pkg::MRX_DW-1:0] acc,
    output logic global_irq_enable,
    output logic foreign_op
);
    import mrx_pkg::*;

    // ============================================================
    // Decode
    // Recognise each op of the subset from a word
    function automatic logic [5:0] mrx_decode(input logic [13:0] w);
        logic [5:0] d;
        d = 6'h00;
        d[0] = (w[13:7] == MRX_STORE_TOP);
        d[1] = (w[13:10] == MRX_LOADLIT_TOP);
        d[2] = (w[13:10] == MRX_RETLIT_TOP);
        d[3] = (w == MRX_IRQRET_WORD);
        d[4] = (w == MRX_SUBRET_WORD);
        d[5] = ((w & MRX_NOP_MASK) == MRX_NOP_WORD);
        return d;
    endfunction

    // ============================================================
    // Decoded signals
    // Flags are one-hot by construction: the subset's patterns are disjoint
    mrx_state_t state;                      // Current cycle type
    mrx_state_t next_state;                 // Next cycle type
    wire logic [5:0] dec = mrx_decode(instr.word);   // Decoded op flags
    wire logic take = ce && instr.valid && instr_ready; // Instruction accepted
    wire logic op_store = dec[0];           // Store accumulator op
    wire logic op_loadlit = dec[1];         // Load literal op
    wire logic op_retlit = dec[2];          // Return with literal op
    wire logic op_irqret = dec[3];          // Interrupt return op
    wire logic op_subret = dec[4];          // Subroutine return op
    wire logic op_nop = dec[5];             // No-operation
    wire logic op_return = op_retlit || op_irqret || op_subret; // Any two-cycle op
    wire logic op_known = |dec;             // Inside this subset
    wire logic [7:0] literal = instr.word[7:0];  // Immediate byte

    // Only one instruction in flight; second return cycle is a fetch bubble
    assign instr_ready = (state == MRX_EXEC);

    // Next state: returns take one extra cycle
    always_comb begin
        next_state = state;
        case (state)
            MRX_EXEC: begin
                // Enter the second cycle after any return
                if (take && op_return) begin
                    next_state = MRX_SECOND; // [RULE_02] [RULE_03] [RULE_05]
                end
            end
            MRX_SECOND: begin
                // Bubble done, back to fetch
                next_state = MRX_EXEC;
            end
            default: begin
                // Recover from an illegal code
                next_state = MRX_EXEC;
            end
        endcase
    end

    // ============================================================
    // State register
    // Frozen by the enable like all other state
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= MRX_EXEC;
        end else if (ce) begin
            state <= next_state;
        end
    end

    // ============================================================
    // Next values of the outputs
    wire mrx_file_wr_t next_file_wr = '{en: take && op_store,
                                        addr: instr.word[6:0],
                                        data: acc}; // [RULE_01]
    wire mrx_pc_ctl_t next_pc_ctl = '{load: take && op_return,
                                      pop: take && op_return,
                                      value: stack_head}; // [RULE_02] [RULE_03] [RULE_05]
    wire logic acc_load = take && (op_loadlit || op_retlit); // [RULE_04] [RULE_06]
    wire logic gie_set = take && op_irqret; // [RULE_02]

    // ============================================================
    // Strobes toward the datapath
    // Pulses last one enabled cycle; status flags are never touched here
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            file_wr <= '0;
            pc_ctl <= '0;
            foreign_op <= 1'b0;
        end else if (ce) begin
            file_wr <= next_file_wr; // [RULE_01]
            pc_ctl <= next_pc_ctl; // [RULE_03] [RULE_05]
            foreign_op <= take && !op_known;
        end
    end

    // ============================================================
    // Accumulator and interrupt enable
    // No-operation falls through both branches, so nothing changes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            acc <= MRX_ACC_RST;
            global_irq_enable <= MRX_GIE_RST;
        end else if (ce) begin
            // Literal ops load the immediate byte
            if (acc_load) begin
                acc <= literal; // [RULE_04] [RULE_06]
            end
            // Only the interrupt return sets the enable; only reset clears it
            if (gie_set) begin
                global_irq_enable <= 1'b1; // [RULE_02]
            end
        end
    end

    // ============================================================
    // Checks
    a_store_copies_acc: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_01]
        (take && op_store) |=> (file_wr.en && file_wr.data == $past(acc)
            && file_wr.addr == $past(instr.word[6:0]) && instr_ready))
        else $error("store did not write accumulator in one cycle");

    a_irqret_sets_gie: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_02]
        (take && op_irqret) |=> (global_irq_enable && pc_ctl.load
            && pc_ctl.value == $past(stack_head) && !instr_ready))
        else $error("interrupt return missed enable or counter load");

    a_subret_two_cycles: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_03]
        (take && op_subret) |=> (pc_ctl.pop && pc_ctl.load && state == MRX_SECOND
            && $stable(acc) && $stable(global_irq_enable)))
        else $error("subroutine return not a two-cycle pop");

    a_retlit_loads_acc: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_04]
        (take && op_retlit) |=> (acc == $past(instr.word[7:0])))
        else $error("return literal did not load accumulator");

    a_retlit_pc_load: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_05]
        (take && op_retlit) ##1 ce |-> (pc_ctl.load && !instr_ready) ##1 instr_ready)
        else $error("return literal not two cycles with counter load");

    a_loadlit_one_cycle: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_06]
        (take && op_loadlit) |=> (acc == $past(instr.word[7:0]) && instr_ready
            && !pc_ctl.load && !file_wr.en))
        else $error("load literal not a one-cycle accumulator write");

    a_nop_no_change: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_06]
        (take && op_nop) |=> ($stable(acc) && $stable(global_irq_enable)
            && !file_wr.en && !pc_ctl.load && !pc_ctl.pop))
        else $error("no-operation changed state");

    a_second_returns: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_03]
        (state == MRX_SECOND && ce) |=> (state == MRX_EXEC && !pc_ctl.load))
        else $error("second return cycle did not end");

    // ============================================================
    // Checks on side effects
    // Each op must leave alone everything it does not own
    a_store_no_side: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_01]
        (take && op_store) |=> ($stable(acc) && $stable(global_irq_enable)
            && !pc_ctl.load && !pc_ctl.pop && !foreign_op))
        else $error("store touched more than the file write");

    // Interrupt return pops as well and keeps the accumulator
    a_irqret_pops_head: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_02]
        (take && op_irqret) |=> (pc_ctl.pop && $stable(acc) && !file_wr.en))
        else $error("interrupt return did not pop or touched accumulator");

    // Subroutine return loads the head sampled at the take
    a_subret_head_value: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_03]
        (take && op_subret) |=> (pc_ctl.value == $past(stack_head) && !instr_ready
            && !file_wr.en))
        else $error("subroutine return loaded a wrong counter value");

    // Return literal reloads the counter without touching the enable
    a_retlit_keeps_gie: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_05]
        (take && op_retlit) |=> (pc_ctl.pop && pc_ctl.value == $past(stack_head)
            && $stable(global_irq_enable) && !file_wr.en))
        else $error("return literal counter load or enable wrong");

    // Load literal is a plain accumulator write
    a_loadlit_keeps_gie: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_06]
        (take && op_loadlit) |=> ($stable(global_irq_enable) && !pc_ctl.pop
            && !foreign_op))
        else $error("load literal touched more than the accumulator");

    // Only the two literal ops may write the accumulator
    a_acc_only_literals: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_06]
        (take && !op_loadlit && !op_retlit) |=> $stable(acc))
        else $error("accumulator changed without a literal op");

    // ============================================================
    // Checks on the clock enable
    // Return bubbles count enabled cycles only, so a low enable must freeze all
    a_frozen_when_off: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_03] [RULE_05]
        (!ce) |=> ($stable(state) && $stable(acc) && $stable(global_irq_enable)
            && $stable(file_wr) && $stable(pc_ctl) && $stable(foreign_op)))
        else $error("state moved while the clock enable was low");

endmodule : mrx_exec

// file: verif/move_return_instr_exec_tb_top.sv
// Self-checking bench for the move/return executor
module move_return_instr_exec_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import mrx_pkg::*;

    // ============================================================
    // Stimulus and observed signals
    logic clk = 1'b0; // 20 MHz core clock
    logic rst_b = 1'b0; // Active-low reset
    logic ce = 1'b1; // High by default; t_clock_enable drops it to freeze the executor
    mrx_instr_t instr = '0; // Word from fetch
    logic [12:0] stack_head = 13'h0000; // Return stack head
    logic instr_ready;
    mrx_file_wr_t file_wr;
    mrx_pc_ctl_t pc_ctl;
    logic [7:0] acc;
    logic global_irq_enable;
    logic foreign_op;
    int miscompares = 0;
    int checks = 0;

    always #25 clk = ~clk;

    mrx_exec uut (.clk(clk), .rst_b(rst_b), .ce(ce), .instr(instr),
        .instr_ready(instr_ready), .stack_head(stack_head), .file_wr(file_wr),
        .pc_ctl(pc_ctl), .acc(acc), .global_irq_enable(global_irq_enable),
        .foreign_op(foreign_op));

    // ============================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Offer one word for one cycle; returns in the cycle after the take
    task automatic issue(input logic [13:0] w);
        @(negedge clk);
        instr.valid = 1'b1;
        instr.word = w;
        @(negedge clk);
        instr.valid = 1'b0;
    endtask

    // Any return: counter reload with pop, bubble, then pulses drop
    task automatic ret_case(input logic [13:0] w, input logic [12:0] head,
                            input logic [7:0] exp_acc, input logic exp_gie);
        stack_head = head;
        issue(w);
        stack_head = ~head; // Stale head must not leak into the value
        check(pc_ctl.load, 1'b1);
        check(pc_ctl.pop, 1'b1);
        check(pc_ctl.value, head);
        check(acc, exp_acc);
        check(global_irq_enable, exp_gie);
        check(instr_ready, 1'b0);
        check(file_wr.en, 1'b0);
        @(negedge clk);
        check({pc_ctl.load, pc_ctl.pop, instr_ready}, 3'b001);
    endtask

    // ============================================================
    // Scenarios
    task automatic t_load_store();
        issue(14'h3300 | 14'h00A5); // Don't-care bits set
        check(acc, 8'hA5);
        issue(14'h0080 | 14'h007F); // Top file address, right after load
        check({file_wr.en, file_wr.addr, file_wr.data}, {1'b1, 7'h7F, 8'hA5});
        check(instr_ready, 1'b1);
        @(negedge clk);
        check(file_wr.en, 1'b0);
    endtask

    task automatic t_returns();
        ret_case(14'h37FF, 13'h1ABC, 8'hFF, 1'b0);
        ret_case(14'h3400, 13'h0001, 8'h00, 1'b0);
        ret_case(14'h0008, 13'h1FFF, 8'h00, 1'b0);
        ret_case(14'h0009, 13'h0555, 8'h00, 1'b1);
        ret_case(14'h0008, 13'h0AAA, 8'h00, 1'b1);
    endtask

    task automatic t_nop_foreign();
        issue(14'h3000 | 14'h005A);
        issue(14'h0060); // No-operation with both don't-care bits set
        check({file_wr.en, pc_ctl.load, pc_ctl.pop, foreign_op}, 4'b0000);
        check(acc, 8'h5A);
        issue(14'h0001); // Outside the subset
        check(foreign_op, 1'b1);
        check({file_wr.en, pc_ctl.load, acc}, {2'b00, 8'h5A});
    endtask

    // Low enable holds the bubble and refuses an offered word
    task automatic t_clock_enable();
        stack_head = 13'h0123;
        issue(14'h3442); // Return literal, taken at an enabled edge
        ce = 1'b0;
        @(negedge clk);
        check({pc_ctl.load, instr_ready, acc}, {2'b10, 8'h42});
        ce = 1'b1;
        @(negedge clk);
        check({pc_ctl.load, instr_ready}, 2'b01);
        ce = 1'b0;
        instr.valid = 1'b1;
        instr.word = 14'h3011; // Offered while frozen, must wait
        @(negedge clk);
        check(acc, 8'h42);
        ce = 1'b1;
        @(negedge clk);
        instr.valid = 1'b0;
        check(acc, 8'h11);
    endtask

    // ============================================================
    // Verdict, reached from the main sequence or the watchdog
    task automatic results();
        if (miscompares == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog at 2000 cycles, well above the 40 or so cycles the tests need
    initial begin
        #(2000 * 50);
        miscompares++;
        results();
    end

    // Main sequence
    initial begin
        repeat (8) @(negedge clk);
        check({acc, global_irq_enable, instr_ready}, {MRX_ACC_RST, MRX_GIE_RST, 1'b1});
        rst_b = 1'b1;
        t_load_store();
        t_returns();
        t_clock_enable();
        t_nop_foreign();
        results();
    end
endmodule // move_return_instr_exec_tb_top
